// ### rtl/addr_wake_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ADDR_WAKE_CONSTS_SVH
`define ADDR_WAKE_CONSTS_SVH
`define AW_OFS_MODE       8'h00
`define AW_OFS_SLAVE_ADDR 8'h04
`define AW_OFS_BUS_STAT   8'h08
`define AW_OFS_IRQ_STAT   8'h0C
`define AW_OFS_IRQ_MASK   8'h10
`define AW_OFS_RX_DATA    8'h14
`define AW_BIT_ENABLE     7
`define AW_BIT_MATCH      6
`define AW_BIT_WAKE       5
`define AW_BIT_ADDR_MODE  4
`define AW_BIT_CMD        3
`define AW_BIT_REL        2
`define AW_IRQ_XFER       0
`define AW_IRQ_WAKE       1
`define AW_MODE_RESET     8'h00
`define AW_ADDR_RESET     8'h00
`define AW_MASK_RESET     2'h0
`define AW_XFER_BITS      4'h8
`endif

// ### rtl/addr_wake_pkg.sv
// Types shared by the address-match wakeup block.
package addr_wake_pkg;
	typedef struct packed {
		logic       enable;
		logic       wake_sel;
		logic       addr_mode;
		logic [7:0] slave_addr;
	} ctrl_s;
	typedef struct packed {
		logic       done;
		logic [7:0] data;
	} xfer_s;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_RELEASE = 2'b01,
		ST_ADDRESS = 2'b10
	} wake_e;
endpackage

// ### rtl/pin_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	initial begin
		if (WIDTH < 1) $error("pin_sync width must be positive");
	end

	always_comb begin
		meta_d = ce_i ? async_i : meta_q;
		sync_d = ce_i ? meta_q : sync_q;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule

// ### rtl/serial_shifter.sv
// Receive shift register clocked by the sampled serial clock.
`timescale 1ns/1ps
`include "addr_wake_consts.svh"
module serial_shifter (
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 ce_i,
	input  wire logic                 enable_i,
	input  wire logic                 sck_i,
	input  wire logic                 sdi_i,
	input  wire logic                 restart_i,
	output addr_wake_pkg::xfer_s      xfer_o
);
	logic       sck_q;
	logic       sck_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [3:0] count_q;
	logic [3:0] count_d;
	logic       done_q;
	logic       done_d;

	always_comb begin
		sck_d   = sck_i;
		shift_d = shift_q;
		count_d = count_q;
		done_d  = 1'b0;
		if (!enable_i || restart_i) begin
			count_d = 4'h0;
		end else if (sck_i && !sck_q) begin
			shift_d = {shift_q[6:0], sdi_i};
			if (count_d == `AW_XFER_BITS - 4'h1) begin
				count_d = 4'h0;
				done_d  = 1'b1;
			end else begin
				count_d = count_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sck_q   <= 1'b0;
			shift_q <= 8'h00;
			count_q <= 4'h0;
			done_q  <= 1'b0;
		end else if (ce_i) begin
			sck_q   <= sck_d;
			shift_q <= shift_d;
			count_q <= count_d;
			done_q  <= done_d;
		end
	end

	assign xfer_o.done = done_q;
	assign xfer_o.data = shift_q;
endmodule

// ### rtl/serial_address_match_wakeup.sv
// Address-match wakeup control slice with Wishbone registers.
// What this block does
// - Wake select 0: interrupt every transfer.
// - Wake select 1 with address mode 1: interrupt on matching post-release address.
// - Match flag equals slave address comparison.
// - Operation disabled forces match flag zero.
// - Match flag bit 6, read-only.
`timescale 1ns/1ps
`include "addr_wake_consts.svh"
module serial_address_match_wakeup (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        serial_clock_pin_i,
	input  wire logic        serial_data_i,
	input  wire logic        command_detect_flag_i,
	input  wire logic        release_detect_flag_i,
	output logic             serial_operation_enable_o,
	output logic             address_match_flag_o,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// Registers and synchronised pins.
	// ------------------------------------------------------------
	addr_wake_pkg::ctrl_s  ctrl_q;
	addr_wake_pkg::ctrl_s  ctrl_d;
	addr_wake_pkg::xfer_s  xfer;
	addr_wake_pkg::wake_e  state_q;
	addr_wake_pkg::wake_e  state_d;
	logic [1:0]            stat_q;
	logic [1:0]            stat_d;
	logic [1:0]            mask_q;
	logic [1:0]            mask_d;
	logic                  ack_q;
	logic                  ack_d;
	logic                  err_q;
	logic                  err_d;
	logic [31:0]           rdat_q;
	logic [31:0]           rdat_d;
	logic [3:0]            pins;
	logic                  match;
	logic                  released;
	logic [1:0]            event_set;
	logic                  req;
	logic                  wr_lane0;

	pin_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_i  (clk_i),
		.reset_i(reset_i),
		.ce_i   (ce_i),
		.async_i({serial_data_i, serial_clock_pin_i,
			command_detect_flag_i, release_detect_flag_i}),
		.sync_o (pins)
	);

	serial_shifter u_shift (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.ce_i     (ce_i),
		.enable_i (ctrl_q.enable),
		.sck_i    (pins[2]),
		.sdi_i    (pins[3]),
		.restart_i(1'b0),
		.xfer_o   (xfer)
	);

	// ------------------------------------------------------------
	// Address comparison and wakeup sequencing.
	// ------------------------------------------------------------
	assign match = ctrl_q.enable && (ctrl_q.slave_addr == xfer.data);
	assign released = pins[1] && pins[0];

	always_comb begin
		state_d   = state_q;
		event_set = 2'b00;
		if (!ctrl_q.enable) begin
			state_d = addr_wake_pkg::ST_IDLE;
		end else begin
			if (xfer.done) begin
				event_set[`AW_IRQ_XFER] = !ctrl_q.wake_sel;
			end
			case (state_q)
				addr_wake_pkg::ST_IDLE: begin
					if (released) begin
						state_d = addr_wake_pkg::ST_RELEASE;
					end
				end
				addr_wake_pkg::ST_RELEASE: begin
					state_d = addr_wake_pkg::ST_ADDRESS;
				end
				addr_wake_pkg::ST_ADDRESS: begin
					if (xfer.done) begin
						state_d = addr_wake_pkg::ST_IDLE;
						event_set[`AW_IRQ_WAKE] = ctrl_q.wake_sel
							&& ctrl_q.addr_mode
							&& (ctrl_q.slave_addr == xfer.data);
					end
				end
				default: begin
					state_d = addr_wake_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave.
	// ------------------------------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		stat_d = stat_q | event_set;
		ack_d  = 1'b0;
		err_d  = 1'b0;
		rdat_d = rdat_q;
		if (req) begin
			ack_d  = 1'b1;
			rdat_d = 32'h0000_0000;
			if (wb_adr_i == `AW_OFS_MODE) begin
				rdat_d[`AW_BIT_ENABLE]    = ctrl_q.enable;
				rdat_d[`AW_BIT_MATCH]     = match;
				rdat_d[`AW_BIT_WAKE]      = ctrl_q.wake_sel;
				rdat_d[`AW_BIT_ADDR_MODE] = ctrl_q.addr_mode;
				if (wr_lane0) begin
					ctrl_d.enable    = wb_dat_i[`AW_BIT_ENABLE];
					ctrl_d.wake_sel  = wb_dat_i[`AW_BIT_WAKE];
					ctrl_d.addr_mode = wb_dat_i[`AW_BIT_ADDR_MODE];
				end
			end else if (wb_adr_i == `AW_OFS_SLAVE_ADDR) begin
				rdat_d[7:0] = ctrl_q.slave_addr;
				if (wr_lane0) begin
					ctrl_d.slave_addr = wb_dat_i[7:0];
				end
			end else if (wb_adr_i == `AW_OFS_BUS_STAT) begin
				rdat_d[`AW_BIT_CMD] = pins[1];
				rdat_d[`AW_BIT_REL] = pins[0];
			end else if (wb_adr_i == `AW_OFS_IRQ_STAT) begin
				rdat_d[1:0] = stat_q;
				if (wr_lane0) begin
					stat_d = (stat_q & ~wb_dat_i[1:0]) | event_set;
				end
			end else if (wb_adr_i == `AW_OFS_IRQ_MASK) begin
				rdat_d[1:0] = mask_q;
				if (wr_lane0) begin
					mask_d = wb_dat_i[1:0];
				end
			end else if (wb_adr_i == `AW_OFS_RX_DATA) begin
				rdat_d[7:0] = xfer.data;
			end else begin
				ack_d = 1'b0;
				err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_q  <= {1'b0, 1'b0, 1'b0, `AW_ADDR_RESET};
			mask_q  <= `AW_MASK_RESET;
			stat_q  <= 2'h0;
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdat_q  <= 32'h0000_0000;
			state_q <= addr_wake_pkg::ST_IDLE;
		end else if (ce_i) begin
			ctrl_q  <= ctrl_d;
			mask_q  <= mask_d;
			stat_q  <= stat_d;
			ack_q   <= ack_d;
			err_q   <= err_d;
			rdat_q  <= rdat_d;
			state_q <= state_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;
	assign irq_o = |(stat_q & mask_q);
	assign serial_operation_enable_o = ctrl_q.enable;
	assign address_match_flag_o = match;

	// ------------------------------------------------------------
	// Assertions on the match flag.
	// ------------------------------------------------------------
	a_match_off_zero: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!serial_operation_enable_o |-> !address_match_flag_o)
		else $error("match flag set while disabled");
	a_match_compare: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ctrl_q.enable |->
		(address_match_flag_o == (ctrl_q.slave_addr == xfer.data)))
		else $error("match flag disagrees with compare");
	a_mode_ro_bit: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && req && !wb_we_i && wb_adr_i == `AW_OFS_MODE)
		|=> wb_dat_o[`AW_BIT_MATCH] == $past(match))
		else $error("mode read lost match bit");
	a_match_no_write: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && wr_lane0 && wb_adr_i == `AW_OFS_MODE
		&& !wb_dat_i[`AW_BIT_ENABLE]) |=> !address_match_flag_o)
		else $error("match bit followed a write");

	// ------------------------------------------------------------
	// Assertions on the interrupt events and the sequencer.
	// ------------------------------------------------------------
	a_xfer_irq_set: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && xfer.done && ctrl_q.enable && !ctrl_q.wake_sel)
		|=> stat_q[`AW_IRQ_XFER])
		else $error("transfer did not set status");
	a_wake_no_xfer: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && ctrl_q.wake_sel && !stat_q[`AW_IRQ_XFER] && !req)
		|=> !stat_q[`AW_IRQ_XFER])
		else $error("transfer irq raised in wake mode");
	a_wake_needs_addr: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && event_set[`AW_IRQ_WAKE])
		|-> state_q == addr_wake_pkg::ST_ADDRESS && match)
		else $error("wake irq without matching address");
	a_wake_mode_gate: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && event_set[`AW_IRQ_WAKE])
		|-> ctrl_q.wake_sel && ctrl_q.addr_mode)
		else $error("wake irq outside addressed mode");
	a_release_seen: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && ctrl_q.enable && released
		&& state_q == addr_wake_pkg::ST_IDLE)
		|=> state_q == addr_wake_pkg::ST_RELEASE)
		else $error("release not taken");
	a_release_addr: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && ctrl_q.enable
		&& state_q == addr_wake_pkg::ST_RELEASE)
		|=> state_q == addr_wake_pkg::ST_ADDRESS)
		else $error("address phase not entered");
	a_disable_idle: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && !ctrl_q.enable) |=> state_q == addr_wake_pkg::ST_IDLE)
		else $error("sequencer ran while disabled");
	a_disable_quiet: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!ctrl_q.enable |-> event_set == 2'b00)
		else $error("event raised while disabled");
	a_done_pulse: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && xfer.done) |=> !xfer.done)
		else $error("transfer done held");

	// ------------------------------------------------------------
	// Assertions on the register bus and the interrupt line.
	// ------------------------------------------------------------
	a_bus_answer: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && req) |=> (wb_ack_o ^ wb_err_o))
		else $error("request not answered");
	a_ack_pulse: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && (wb_ack_o || wb_err_o)) |=> !(wb_ack_o || wb_err_o))
		else $error("answer held past one cycle");
	a_err_unmapped: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && req && wb_adr_i > `AW_OFS_RX_DATA) |=> wb_err_o)
		else $error("unmapped access not refused");
	a_mode_write: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && wr_lane0 && wb_adr_i == `AW_OFS_MODE)
		|=> ctrl_q.enable == $past(wb_dat_i[`AW_BIT_ENABLE]))
		else $error("enable bit not written");
	a_mask_write: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && wr_lane0 && wb_adr_i == `AW_OFS_IRQ_MASK)
		|=> mask_q == $past(wb_dat_i[1:0]))
		else $error("mask not written");
	a_stat_sticky: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!(req && wb_we_i && wb_adr_i == `AW_OFS_IRQ_STAT)
		|=> (stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status bit lost without a clear");
	a_stat_clear: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && wr_lane0 && wb_adr_i == `AW_OFS_IRQ_STAT
		&& wb_dat_i[`AW_IRQ_XFER] && !event_set[`AW_IRQ_XFER])
		|=> !stat_q[`AW_IRQ_XFER])
		else $error("transfer status not cleared");
	a_ce_freeze: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!ce_i |=> $stable(ctrl_q) && $stable(stat_q) && $stable(state_q))
		else $error("state moved while frozen");
	a_irq_level: assert property (
		@(posedge clk_i) disable iff (reset_i)
		irq_o == |(stat_q & mask_q))
		else $error("interrupt level wrong");
endmodule

// ### verification/bus_station.sv
// Serial bus station that clocks bytes and bus releases into the block.
`timescale 1ns/1ps
module bus_station (
	output logic sck_o,
	output logic sdo_o,
	output logic cmd_o,
	output logic rel_o
);
	initial begin
		sck_o <= 1'b1;
		sdo_o <= 1'b1;
		cmd_o <= 1'b0;
		rel_o <= 1'b0;
	end
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sck_o <= 1'b0;
			sdo_o <= b[i];
			#40;
			sck_o <= 1'b1;
			#40;
		end
		#40;
		sdo_o <= ~b[0];
	endtask
	task automatic release_bus;
		cmd_o <= 1'b1;
		rel_o <= 1'b1;
		#200;
		cmd_o <= 1'b0;
		rel_o <= 1'b0;
		#100;
	endtask
endmodule

// ### verification/tb_serial_address_match_wakeup.sv
// Self-checking bench for the address-match wakeup block.
`timescale 1ns/1ps
module tb_serial_address_match_wakeup;
	logic        clk_i   = 1'b0;
	logic        reset_i = 1'b1;
	logic        cyc     = 1'b0;
	logic        we      = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic [31:0] wdat    = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] d;
	logic        e;
	logic        ce      = 1'b1;
	logic        interrupt_timing_select_bit = 1'b1;
	logic        ack, err, sck, sdo, cmd, rel, en, match, irq;
	int          bad_count = 0;
	int          n_tests   = 0;
	always #5 clk_i = ~clk_i;
	serial_address_match_wakeup u_serial_address_match_wakeup (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .serial_clock_pin_i(sck),
		.serial_data_i(sdo), .command_detect_flag_i(cmd),
		.release_detect_flag_i(rel), .serial_operation_enable_o(en),
		.address_match_flag_o(match), .irq_o(irq)
	);
	bus_station u_bus_station (
		.sck_o(sck), .sdo_o(sdo), .cmd_o(cmd), .rel_o(rel)
	);
	// ------------------------------------------------------------
	// Bus access and comparison tasks.
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
	                  input logic [31:0] v);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (!(ack === 1'b1 || err === 1'b1) && k < 20);
		if (k >= 20) begin
			bad_count++;
			end_sim;
		end
		d = rdat;
		e = err;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		wb(1'b0, a, 32'h0000_0000);
		chk(d, x);
	endtask
	task automatic byte_in(input logic [7:0] b);
		u_bus_station.send_byte(b);
		repeat (8) @(posedge clk_i);
	endtask
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int a = 0; a < 24; a += 4) begin
			rd(a[7:0], 32'h0000_0000);
		end
		wb(1'b0, 8'h20, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		chk(32'(match), 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0040);
		rd(8'h00, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0080);
		rd(8'h00, 32'h0000_00C0);
		chk(32'(en), 32'h0000_0001);
		wb(1'b1, 8'h10, 32'h0000_0001);
		byte_in(8'h5A);
		ce <= 1'b0;
		byte_in(8'h0F);
		ce <= 1'b1;
		rd(8'h14, 32'h0000_005A);
		rd(8'h0C, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		chk(32'(match), 32'h0000_0000);
		wb(1'b1, 8'h0C, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		wb(1'b1, 8'h04, 32'h0000_005A);
		rd(8'h00, 32'h0000_00C0);
		wb(1'b1, 8'h00, 32'h0000_0000);
		chk(32'(match), 32'h0000_0000);
		byte_in(8'hFF);
		rd(8'h0C, 32'h0000_0000);
		wb(1'b1, 8'h04, 32'h0000_00A5);
		interrupt_timing_select_bit = 1'b0;
		wb(1'b1, 8'h00, interrupt_timing_select_bit ?
		   32'h0000_0090 : 32'h0000_00B0);
		wb(1'b1, 8'h10, 32'h0000_0002);
		fork
			u_bus_station.release_bus;
			begin
				repeat (12) @(posedge clk_i);
				rd(8'h08, 32'h0000_000C);
			end
		join
		byte_in(8'hA5);
		rd(8'h0C, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0001);
		chk(32'(match), 32'h0000_0001);
		wb(1'b1, 8'h10, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		wb(1'b1, 8'h0C, 32'h0000_0003);
		u_bus_station.release_bus;
		byte_in(8'h3C);
		byte_in(8'hA5);
		rd(8'h0C, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_00A0);
		wb(1'b1, 8'h10, 32'h0000_0002);
		u_bus_station.release_bus;
		byte_in(8'hA5);
		rd(8'h0C, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		end_sim;
	end
endmodule
